// >>> security_alarm_pkg.sv
// How it works
// - Out-of-range sensor forces reset or exception
// - RAM words carry parity checked on read
// - Idle-cycle scrubber checks RAM in random order
// - Any parity mismatch forces a security reset
// - Reset restores defaults; reset cause stays readable
// - Each cycle's highest-priority exception leaves a readable reason code
// - Software has no way to disable sensors
// - Three stack pointers, each with limit checks
// - Active stack pointer outside limits raises exception
// - Check write high voltage every EEPROM write
// - High-voltage result is register only, no event
// - Inverse correction option turns ECC errors into exceptions
// - Software switch enables EEPROM double-read detection
// - Watchdog stays off until software enables it
// - Disabled coprocessor access is refused with exception
package security_alarm_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_WD_LOAD = 8'h10;
  localparam logic [7:0] ADDR_WD_KICK = 8'h14;
  localparam logic [7:0] ADDR_CAUSE = 8'h18;
  localparam logic [7:0] ADDR_REASON = 8'h1c;
  localparam logic [7:0] ADDR_HV = 8'h20;
  localparam logic [7:0] ADDR_RAM_ADDR = 8'h24;
  localparam logic [7:0] ADDR_RAM_DATA = 8'h28;
  // Stack limits: low word then high word, one pair per level.
  localparam logic [7:0] ADDR_SP_BASE = 8'h30;
  localparam logic [7:0] ADDR_SP_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_SP_HI = 8'h04;
  // Event bit positions in status, clear and enable.
  localparam int EV_SENSOR = 0;
  localparam int EV_STACK = 1;
  localparam int EV_ECC = 2;
  localparam int EV_COPRO = 3;
  localparam int NUM_EV = 4;
  // Control bit positions.
  localparam int CTRL_DBLREAD = 0;
  localparam int CTRL_INVECC = 1;
  localparam int CTRL_WDEN = 2;
  localparam int CTRL_W = 3;
  // High-voltage result bit positions.
  localparam int HV_PASS = 0;
  localparam int HV_DONE = 1;
  // Privilege levels: user, system, most privileged.
  localparam int NLVL = 3;
  localparam logic [1:0] PRIV_TOP = 2'h2;
  // Reset values.
  localparam logic [15:0] WD_LOAD_RST = 16'h00ff;
  localparam logic [15:0] SP_LO_RST = 16'h0000;
  localparam logic [15:0] SP_HI_RST = 16'hffff;
  localparam logic [3:0] LFSR_SEED = 4'h1;
  localparam int LFSR_W = 4;
  // Watchdog tick period and its length in core clock cycles.
  localparam int CLK_HZ = 40_000_000;
  localparam int WD_TICK_NS = 1000;
  localparam int WD_TICK_CYC = WD_TICK_NS / (1_000_000_000 / CLK_HZ);
  // Reset cause and exception reason codes.
  typedef enum logic [1:0] {
    CAUSE_POWER, CAUSE_SENSOR, CAUSE_PARITY, CAUSE_WATCHDOG
  } cause_t;
  typedef enum logic [2:0] {
    RSN_NONE, RSN_SENSOR, RSN_STACK, RSN_ECC, RSN_COPRO
  } reason_t;
endpackage : security_alarm_pkg

// >>> stack_limit_check.sv
`timescale 1ns/100ps
`default_nettype none
// Range checker for one privilege level's stack pointer.
module stack_limit_check #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Pointer and its limits.
  input wire logic active,
  input wire logic [W-1:0] sp,
  input wire logic [W-1:0] lowLimit,
  input wire logic [W-1:0] highLimit,
  // Registered violation flag.
  output logic overrun
);
  logic next_overrun; // Violation seen this cycle.

  if (W < 2) begin : gBadWidth
    $error("stack_limit_check: width too small");
  end

  // Only the level in use is checked, so idle levels never fire.
  always_comb begin
    next_overrun = active && (sp < lowLimit || sp > highLimit);
  end

  // Register the result.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun <= 1'b0;
    end else begin
      overrun <= next_overrun;
    end
  end

  AST_STACK_OVER: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    active && (sp > highLimit || sp < lowLimit) |=> overrun)
    else $error("Stack violation not flagged.");
endmodule : stack_limit_check
`default_nettype wire

// >>> ram_parity_scrub.sv
`timescale 1ns/100ps
`default_nettype none
// Parity-protected RAM with a background scrubber.
module ram_parity_scrub #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Software access port.
  input wire logic cpuEn,
  input wire logic cpuWe,
  input wire logic [AW-1:0] cpuAddr,
  input wire logic [DW-1:0] cpuWdata,
  output logic [DW-1:0] cpuRdata,
  output logic cpuParityErr,
  // Scrubber result.
  output logic scrubErr
);
  localparam int DEPTH = 1 << AW;
  logic [DW-1:0] mem [DEPTH]; // Data words.
  logic par [DEPTH]; // One parity bit per word.
  logic [DW-1:0] next_mem [DEPTH];
  logic next_par [DEPTH];
  logic [AW-1:0] lfsr, next_lfsr; // Scrub address.
  logic next_scrubErr;

  // The feedback taps are fixed for the package's width.
  if (AW != security_alarm_pkg::LFSR_W || DW < 1) begin : gBadSize
    $error("ram_parity_scrub: unsupported size");
  end

  // Read side: parity recomputed and compared on every read.
  always_comb begin
    cpuRdata = mem[cpuAddr];
    cpuParityErr = cpuEn && !cpuWe &&
      ((^mem[cpuAddr]) != par[cpuAddr]);
  end

  // Writes store the parity beside the data; the scrubber only moves
  // in cycles without software access, so it never steals a port.
  always_comb begin
    next_mem = mem;
    next_par = par;
    if (cpuEn && cpuWe) begin
      next_mem[cpuAddr] = cpuWdata;
      next_par[cpuAddr] = ^cpuWdata;
    end
    // Maximal LFSR with the all-zero state spliced in covers each word.
    next_lfsr = lfsr;
    next_scrubErr = 1'b0;
    if (!cpuEn) begin
      next_lfsr = {lfsr[AW-2:0],
        lfsr[AW-1] ^ lfsr[AW-2] ^ (lfsr[AW-2:0] == '0)};
      next_scrubErr = (^mem[lfsr]) != par[lfsr];
    end
  end

  // Register the store and the scrubber.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
        par[i] <= 1'b0;
      end
      lfsr <= security_alarm_pkg::LFSR_SEED;
      scrubErr <= 1'b0;
    end else begin
      mem <= next_mem;
      par <= next_par;
      lfsr <= next_lfsr;
      scrubErr <= next_scrubErr;
    end
  end

  AST_SCRUB_IDLE: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    cpuEn |=> $stable(lfsr) && !scrubErr)
    else $error("Scrubber moved during software access.");
endmodule : ram_parity_scrub
`default_nettype wire

// >>> security_alarm_controller.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Gathers alarm sources into security resets and exceptions.
module security_alarm_controller #(
  parameter int NSENS = 4,
  parameter logic [NSENS-1:0] RESET_MASK = 4'h3,
  parameter int SPW = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Operating-condition sensors.
  input wire logic [NSENS-1:0] opcAlarm,
  // CPU stack pointer and privilege level.
  input wire logic [SPW-1:0] spValue,
  input wire logic [1:0] privLevel,
  // EEPROM status and control.
  input wire logic eccError,
  input wire logic eeWriteActive,
  input wire logic hvGood,
  output logic eeDoubleRead,
  // Coprocessor gate.
  input wire logic [1:0] coproReq,
  input wire logic [1:0] coproDisable,
  output logic [1:0] coproGrant,
  // System outputs.
  output logic secReset,
  output logic irq
);
  localparam int NLVL = security_alarm_pkg::NLVL;
  localparam int NEV = security_alarm_pkg::NUM_EV;
  localparam int TW = $clog2(security_alarm_pkg::WD_TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST =
    TW'(security_alarm_pkg::WD_TICK_CYC - 1);

  if (NSENS < 1 || SPW < 2 || SPW > 32) begin : gBadParam
    $error("security_alarm_controller: unsupported parameters");
  end

  // Software configuration.
  logic [security_alarm_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [NEV-1:0] irqEnable, next_irqEnable; // Interrupt enables.
  logic [15:0] wdLoad, next_wdLoad; // Watchdog reload value.
  logic [3:0] ramAddr, next_ramAddr; // Word pointer into the RAM.
  logic [SPW-1:0] spLo [NLVL]; // Per-level low limits.
  logic [SPW-1:0] spHi [NLVL]; // Per-level high limits.
  logic [SPW-1:0] next_spLo [NLVL];
  logic [SPW-1:0] next_spHi [NLVL];
  // Event state.
  logic [NEV-1:0] status, next_status; // Sticky event bits.
  logic [NEV-1:0] evt; // Events seen this cycle.
  logic [NEV-1:0] clr; // Clear request from software.
  security_alarm_pkg::reason_t reason, next_reason;
  security_alarm_pkg::cause_t cause, next_cause;
  logic next_secReset, next_irq, next_eeDoubleRead;
  logic [1:0] next_coproGrant;
  logic eeWrPrev, next_eeWrPrev; // Write sequence seen last cycle.
  logic hvFail, next_hvFail; // Low voltage seen in this sequence.
  logic [1:0] hvStat, next_hvStat; // Last sequence: done, pass.
  logic sensReset, sensExc; // Sensor alarms split by class.
  // Watchdog.
  logic [TW-1:0] tickCnt, next_tickCnt; // Prescaler.
  logic tick; // One-cycle enable every tick period.
  logic [15:0] wdCount, next_wdCount;
  logic wdExpire; // Counter ran out while enabled.
  logic [31:0] next_regRdata;
  // RAM and stack checkers.
  logic ramEn, ramWe, ramParErr, scrubErr;
  logic [7:0] ramRdata;
  logic [NLVL-1:0] overrun;
  logic [1:0] lvlSel; // Level whose pointer is in use.

  // Byte address of one stack limit word.
  function automatic logic [7:0] spAddr(input int l, input logic hi);
    spAddr = security_alarm_pkg::ADDR_SP_BASE +
      8'(l) * security_alarm_pkg::ADDR_SP_STRIDE +
      (hi ? security_alarm_pkg::ADDR_SP_HI : 8'h00);
  endfunction : spAddr

  // RAM access decode: only the data window touches the array.
  always_comb begin
    ramWe = regWr && regAddr == security_alarm_pkg::ADDR_RAM_DATA;
    ramEn = ramWe || (regRd && regAddr == security_alarm_pkg::ADDR_RAM_DATA);
  end

  ram_parity_scrub #(.AW(4), .DW(8)) uRam (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .cpuEn(ramEn),
    .cpuWe(ramWe),
    .cpuAddr(ramAddr),
    .cpuWdata(regWdata[7:0]),
    .cpuRdata(ramRdata),
    .cpuParityErr(ramParErr),
    .scrubErr(scrubErr)
  );

  // The most privileged level also covers the unused code.
  always_comb begin
    lvlSel = (privLevel > security_alarm_pkg::PRIV_TOP) ?
      security_alarm_pkg::PRIV_TOP : privLevel;
  end

  // One checker per level, each with its own limit pair.
  for (genvar l = 0; l < NLVL; l++) begin : gStack
    stack_limit_check #(.W(SPW)) uCheck (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .active(lvlSel == 2'(l)),
      .sp(spValue),
      .lowLimit(spLo[l]),
      .highLimit(spHi[l]),
      .overrun(overrun[l])
    );
  end

  // Configuration registers. There is deliberately no bit that
  // reaches a sensor: the only sensor path is the alarm input.
  always_comb begin
    next_ctrl = ctrl;
    next_irqEnable = irqEnable;
    next_wdLoad = wdLoad;
    next_ramAddr = ramAddr;
    next_spLo = spLo;
    next_spHi = spHi;
    if (regWr) begin
      unique case (regAddr)
        security_alarm_pkg::ADDR_CTRL: begin
          // Upper bits are dropped, so no sensor can be switched off.
          next_ctrl = regWdata[security_alarm_pkg::CTRL_W-1:0];
        end
        security_alarm_pkg::ADDR_ENABLE: begin
          next_irqEnable = regWdata[NEV-1:0];
        end
        security_alarm_pkg::ADDR_WD_LOAD: begin
          next_wdLoad = regWdata[15:0];
        end
        security_alarm_pkg::ADDR_RAM_ADDR: begin
          next_ramAddr = regWdata[3:0];
        end
        default: begin
          for (int l = 0; l < NLVL; l++) begin
            if (regAddr == spAddr(l, 1'b0)) begin
              next_spLo[l] = regWdata[SPW-1:0];
            end
            if (regAddr == spAddr(l, 1'b1)) begin
              next_spHi[l] = regWdata[SPW-1:0];
            end
          end
        end
      endcase
    end
    // A security reset returns every setting to its reset value.
    if (secReset) begin
      next_ctrl = '0;
      next_irqEnable = '0;
      next_wdLoad = security_alarm_pkg::WD_LOAD_RST;
      next_ramAddr = '0;
      for (int l = 0; l < NLVL; l++) begin
        next_spLo[l] = SPW'(security_alarm_pkg::SP_LO_RST);
        next_spHi[l] = SPW'(security_alarm_pkg::SP_HI_RST);
      end
    end
  end

  // Register the configuration.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= '0;
      irqEnable <= '0;
      wdLoad <= security_alarm_pkg::WD_LOAD_RST;
      ramAddr <= '0;
      for (int l = 0; l < NLVL; l++) begin
        spLo[l] <= SPW'(security_alarm_pkg::SP_LO_RST);
        spHi[l] <= SPW'(security_alarm_pkg::SP_HI_RST);
      end
    end else begin
      ctrl <= next_ctrl;
      irqEnable <= next_irqEnable;
      wdLoad <= next_wdLoad;
      ramAddr <= next_ramAddr;
      spLo <= next_spLo;
      spHi <= next_spHi;
    end
  end

  // Watchdog: held at its reload value while off, counts ticks once on.
  always_comb begin
    tick = tickCnt == TICK_LAST;
    next_tickCnt = tick ? '0 : tickCnt + TW'(1);
    wdExpire = ctrl[security_alarm_pkg::CTRL_WDEN] && tick &&
      wdCount == '0;
    next_wdCount = wdCount;
    if (!ctrl[security_alarm_pkg::CTRL_WDEN] ||
        (regWr && regAddr == security_alarm_pkg::ADDR_WD_KICK)) begin
      next_wdCount = wdLoad;
    end else if (tick && wdCount != '0) begin
      next_wdCount = wdCount - 16'h0001;
    end
    if (secReset) begin
      next_wdCount = security_alarm_pkg::WD_LOAD_RST;
    end
  end

  // Register the watchdog.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= '0;
      wdCount <= security_alarm_pkg::WD_LOAD_RST;
    end else begin
      tickCnt <= next_tickCnt;
      wdCount <= next_wdCount;
    end
  end

  // Event handling. Fatal sources go to the reset output, the others
  // set sticky bits; a new event beats a clear in the same cycle.
  always_comb begin
    sensReset = |(opcAlarm & RESET_MASK);
    sensExc = |(opcAlarm & ~RESET_MASK);
    evt = '0;
    evt[security_alarm_pkg::EV_SENSOR] = sensExc;
    evt[security_alarm_pkg::EV_STACK] = |overrun;
    evt[security_alarm_pkg::EV_ECC] = eccError &&
      ctrl[security_alarm_pkg::CTRL_INVECC];
    evt[security_alarm_pkg::EV_COPRO] =
      |(coproReq & coproDisable);
    clr = (regWr && regAddr == security_alarm_pkg::ADDR_CLEAR) ?
      regWdata[NEV-1:0] : '0;
    next_status = (status & ~clr) | evt;
    // The reason names the highest-priority event of the cycle.
    next_reason = reason;
    if (sensExc) begin
      next_reason = security_alarm_pkg::RSN_SENSOR;
    end else if (|overrun) begin
      next_reason = security_alarm_pkg::RSN_STACK;
    end else if (evt[security_alarm_pkg::EV_ECC]) begin
      next_reason = security_alarm_pkg::RSN_ECC;
    end else if (evt[security_alarm_pkg::EV_COPRO]) begin
      next_reason = security_alarm_pkg::RSN_COPRO;
    end
    next_secReset = sensReset || ramParErr || scrubErr ||
      wdExpire;
    // The cause survives the reset it reports.
    next_cause = cause;
    if (sensReset) begin
      next_cause = security_alarm_pkg::CAUSE_SENSOR;
    end else if (ramParErr || scrubErr) begin
      next_cause = security_alarm_pkg::CAUSE_PARITY;
    end else if (wdExpire) begin
      next_cause = security_alarm_pkg::CAUSE_WATCHDOG;
    end
    // Refused coprocessors never see a grant.
    next_coproGrant = coproReq & ~coproDisable;
    next_eeDoubleRead = ctrl[security_alarm_pkg::CTRL_DBLREAD];
    // The voltage verdict is only recorded, never turned into an event.
    next_eeWrPrev = eeWriteActive;
    next_hvFail = hvFail;
    next_hvStat = hvStat;
    if (eeWriteActive) begin
      next_hvFail = (eeWrPrev ? hvFail : 1'b0) || !hvGood;
    end else if (eeWrPrev) begin
      next_hvStat[security_alarm_pkg::HV_DONE] = 1'b1;
      next_hvStat[security_alarm_pkg::HV_PASS] = !hvFail;
    end
    if (secReset) begin
      next_status = '0;
      next_reason = security_alarm_pkg::RSN_NONE;
      next_coproGrant = '0;
      next_eeDoubleRead = 1'b0;
      next_hvFail = 1'b0;
      next_hvStat = '0;
    end
    next_irq = |(next_status & next_irqEnable);
  end

  // Register the event state.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
      reason <= security_alarm_pkg::RSN_NONE;
      cause <= security_alarm_pkg::CAUSE_POWER;
      secReset <= 1'b0;
      irq <= 1'b0;
      coproGrant <= '0;
      eeDoubleRead <= 1'b0;
      eeWrPrev <= 1'b0;
      hvFail <= 1'b0;
      hvStat <= '0;
    end else begin
      status <= next_status;
      reason <= next_reason;
      cause <= next_cause;
      secReset <= next_secReset;
      irq <= next_irq;
      coproGrant <= next_coproGrant;
      eeDoubleRead <= next_eeDoubleRead;
      eeWrPrev <= next_eeWrPrev;
      hvFail <= next_hvFail;
      hvStat <= next_hvStat;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_comb begin
    next_regRdata = '0;
    if (regRd) begin
      unique case (regAddr)
        security_alarm_pkg::ADDR_STATUS: next_regRdata[NEV-1:0] = status;
        security_alarm_pkg::ADDR_ENABLE: next_regRdata[NEV-1:0] = irqEnable;
        security_alarm_pkg::ADDR_CTRL: begin
          next_regRdata[security_alarm_pkg::CTRL_W-1:0] = ctrl;
        end
        security_alarm_pkg::ADDR_WD_LOAD: next_regRdata[15:0] = wdLoad;
        security_alarm_pkg::ADDR_CAUSE: next_regRdata[1:0] = cause;
        security_alarm_pkg::ADDR_REASON: next_regRdata[2:0] = reason;
        security_alarm_pkg::ADDR_HV: next_regRdata[1:0] = hvStat;
        security_alarm_pkg::ADDR_RAM_ADDR: next_regRdata[3:0] = ramAddr;
        security_alarm_pkg::ADDR_RAM_DATA: next_regRdata[7:0] = ramRdata;
        default: begin
          for (int l = 0; l < NLVL; l++) begin
            if (regAddr == spAddr(l, 1'b0)) begin
              next_regRdata[SPW-1:0] = spLo[l];
            end
            if (regAddr == spAddr(l, 1'b1)) begin
              next_regRdata[SPW-1:0] = spHi[l];
            end
          end
        end
      endcase
    end
  end

  // Register the read data.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= '0;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  // An exception-class sensor alarm outside a reset pulse.
  sequence sensExcSeq;
    (|(opcAlarm & ~RESET_MASK)) && !secReset;
  endsequence

  AST_SENSOR_RESET: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    |(opcAlarm & RESET_MASK) |=>
      secReset && cause == security_alarm_pkg::CAUSE_SENSOR)
    else $error("Fatal sensor alarm did not reset.");

  AST_SENSOR_EXC: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    sensExcSeq |=> status[security_alarm_pkg::EV_SENSOR] &&
      reason == security_alarm_pkg::RSN_SENSOR)
    else $error("Sensor exception or reason missing.");

  AST_PARITY_RESET: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    ramParErr || scrubErr |=> secReset ##1 !secReset ||
      cause == security_alarm_pkg::CAUSE_PARITY)
    else $error("Parity error did not reset.");

  AST_RESET_CLEARS: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    secReset |=> ctrl == '0 && irqEnable == '0 && $stable(cause))
    else $error("Security reset left state behind.");

  AST_HV_SILENT: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    eeWriteActive && !hvGood && opcAlarm == '0 && !ramParErr &&
      !scrubErr && !wdExpire && evt == '0 |=> !secReset)
    else $error("Voltage check forced an event.");

  AST_HV_RECORD: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    eeWrPrev && !eeWriteActive && !secReset |=>
      hvStat[security_alarm_pkg::HV_DONE] &&
      hvStat[security_alarm_pkg::HV_PASS] == !$past(hvFail))
    else $error("Voltage result not recorded.");

  AST_WD_OFF: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !ctrl[security_alarm_pkg::CTRL_WDEN] |-> !wdExpire ##1
      wdCount == $past(wdLoad) || $past(secReset))
    else $error("Disabled watchdog is running.");

  AST_ECC_EXC: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    eccError && ctrl[security_alarm_pkg::CTRL_INVECC] && !secReset |=>
      status[security_alarm_pkg::EV_ECC])
    else $error("ECC error raised no exception.");

  AST_COPRO_REFUSE: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    coproReq[0] && coproDisable[0] && !secReset |=>
      !coproGrant[0] && status[security_alarm_pkg::EV_COPRO])
    else $error("Disabled coprocessor was granted.");
endmodule : security_alarm_controller
`default_nettype wire

// >>> cpu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Core side: puts stack pointer, level and requests on the pins.
module cpu_core_model (
  // Clock.
  input wire logic core_clk,
  // Values the bench asks for.
  input wire logic [15:0] wantSp,
  input wire logic [1:0] wantLvl,
  input wire logic [1:0] wantReq,
  // Pins into the controller.
  output logic [15:0] spValue,
  output logic [1:0] privLevel,
  output logic [1:0] coproReq
);
  // Moves only after an edge, as a pipelined core would.
  always @(posedge core_clk) begin
    spValue <= wantSp;
    privLevel <= wantLvl;
    coproReq <= wantReq;
  end
endmodule : cpu_core_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic regWr = 1'b0, regRd = 1'b0, secReset, irq, eeDoubleRead;
  logic [3:0] opcAlarm = 4'h0;
  logic [15:0] wantSp = 16'h0, spValue, r;
  logic [1:0] wantLvl = 2'h0, wantReq = 2'h0, privLevel, coproReq;
  logic [1:0] coproDisable = 2'h0, coproGrant;
  logic eccError = 1'b0, eeWriteActive = 1'b0, hvGood = 1'b1;
  int n_fail = 0, n_compared = 0, lvl, i;
  always #12.5 core_clk = ~core_clk;
  security_alarm_controller dut (.core_clk, .arst_n, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .opcAlarm, .spValue, .privLevel, .eccError,
    .eeWriteActive, .hvGood, .eeDoubleRead, .coproReq, .coproDisable,
    .coproGrant, .secReset, .irq);
  cpu_core_model cpu (.core_clk, .wantSp, .wantLvl, .wantReq, .spValue,
    .privLevel, .coproReq);
  // Upper stack limit address of one level.
  function automatic logic [7:0] hiAddr(input int l);
    return security_alarm_pkg::ADDR_SP_BASE + security_alarm_pkg::ADDR_SP_HI
      + 8'(l) * security_alarm_pkg::ADDR_SP_STRIDE;
  endfunction : hiAddr
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
    // Hand back on an edge so the next drive lands on one too.
    @(posedge core_clk);
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic end_of_test;
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    #2_000_000 n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(84987));
    cyc(4);
    arst_n <= 1'b1;
    rdc(security_alarm_pkg::ADDR_CAUSE, 32'h0);
    rdc(security_alarm_pkg::ADDR_WD_LOAD, 32'hff);
    rdc(8'hfc, 32'h0);
    r = 16'($urandom);
    wr(security_alarm_pkg::ADDR_RAM_ADDR, 32'(r[3:0]));
    wr(security_alarm_pkg::ADDR_RAM_DATA, 32'(r[15:8]));
    rdc(security_alarm_pkg::ADDR_RAM_DATA, 32'(r[15:8]));
    cyc(40);
    rdc(security_alarm_pkg::ADDR_CAUSE, 32'h0);
    // Non-fatal sensor: irq with enable, then masked.
    wr(security_alarm_pkg::ADDR_ENABLE, 32'h1);
    opcAlarm <= 4'h4;
    @(posedge core_clk) opcAlarm <= 4'h0;
    @(posedge core_clk) #1 chk(32'(irq), 32'h1);
    rdc(security_alarm_pkg::ADDR_REASON, 32'h1);
    wr(security_alarm_pkg::ADDR_ENABLE, 32'h0);
    @(posedge core_clk) #1 chk(32'(irq), 32'h0);
    wr(security_alarm_pkg::ADDR_CLEAR, 32'hf);
    // Stack limit: equal to the top is legal, one to 256 above is not.
    lvl = $urandom_range(2);
    wr(hiAddr(lvl), 32'h0100);
    wantLvl <= lvl[1:0];
    wantSp <= 16'h0100;
    cyc(4);
    rdc(security_alarm_pkg::ADDR_STATUS, 32'h0);
    wantSp <= 16'h0101 + 16'($urandom_range(255));
    cyc(4);
    rdc(security_alarm_pkg::ADDR_STATUS, 32'h2);
    rdc(security_alarm_pkg::ADDR_REASON, 32'h2);
    // The bottom limit: equal is legal, one below is not.
    wantSp <= 16'h0080;
    wr(hiAddr(lvl) - security_alarm_pkg::ADDR_SP_HI, 32'h0080);
    cyc(3);
    wr(security_alarm_pkg::ADDR_CLEAR, 32'hf);
    rdc(security_alarm_pkg::ADDR_STATUS, 32'h0);
    wantSp <= 16'h007f;
    cyc(4);
    rdc(security_alarm_pkg::ADDR_STATUS, 32'h2);
    wantSp <= 16'h0080;
    cyc(3);
    wr(security_alarm_pkg::ADDR_CLEAR, 32'hf);
    // Correction errors count only with the inverse option.
    eccError <= 1'b1;
    @(posedge core_clk) eccError <= 1'b0;
    rdc(security_alarm_pkg::ADDR_STATUS, 32'h0);
    wr(security_alarm_pkg::ADDR_CTRL, 32'h3);
    @(posedge core_clk) #1 chk(32'(eeDoubleRead), 32'h1);
    @(posedge core_clk) eccError <= 1'b1;
    @(posedge core_clk) eccError <= 1'b0;
    rdc(security_alarm_pkg::ADDR_STATUS, 32'h4);
    rdc(security_alarm_pkg::ADDR_REASON, 32'h3);
    coproDisable <= 2'b01;
    wantReq <= 2'b11;
    cyc(3);
    #1 chk(32'(coproGrant), 32'h2);
    rdc(security_alarm_pkg::ADDR_STATUS, 32'hc);
    wantReq <= 2'b00;
    cyc(2);
    wr(security_alarm_pkg::ADDR_CLEAR, 32'hf);
    // Programming voltage: one good sequence, then one with the voltage low throughout.
    for (i = 3; i >= 2; i--) begin
      eeWriteActive <= 1'b1;
      hvGood <= i[0];
      cyc(5);
      eeWriteActive <= 1'b0;
      hvGood <= 1'b1;
      cyc(3);
      rdc(security_alarm_pkg::ADDR_HV, 32'(i));
    end
    rdc(security_alarm_pkg::ADDR_STATUS, 32'h0);
    // Watchdog is silent until switched on.
    wr(security_alarm_pkg::ADDR_WD_LOAD, 32'h2);
    cyc(200);
    rdc(security_alarm_pkg::ADDR_CAUSE, 32'h0);
    wr(security_alarm_pkg::ADDR_CTRL, 32'h4);
    // Kicks closer than one tick apart keep the count from running out.
    repeat (6) begin
      cyc(30);
      wr(security_alarm_pkg::ADDR_WD_KICK, 32'($urandom));
    end
    rdc(security_alarm_pkg::ADDR_CAUSE, 32'h0);
    i = 0;
    while (secReset !== 1'b1 && i < 300) begin
      @(posedge core_clk) #1 i++;
    end
    chk(32'(i < 300), 32'h1);
    rdc(security_alarm_pkg::ADDR_CAUSE, 32'h3);
    rdc(security_alarm_pkg::ADDR_CTRL, 32'h0);
    // Fatal sensor still resets after software set every control bit but the watchdog enable.
    wr(security_alarm_pkg::ADDR_CTRL, 32'hffff_fffb);
    rdc(security_alarm_pkg::ADDR_CTRL, 32'h3);
    opcAlarm <= 4'h1;
    @(posedge core_clk) opcAlarm <= 4'h0;
    #1 chk(32'(secReset), 32'h1);
    rdc(security_alarm_pkg::ADDR_CAUSE, 32'h1);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
